// *** hdl/system_watchdog.v ***
/*
 System watchdog with prewarning NMI, password access, init-done lock
 line and double-reset hold, reached over AXI4-Lite.
 Assumes nrst is the power-on reset and that the reset generator acts
 on sysResetReq; one clock at 100 MHz.
*/
// The register addresses and register access over AXI4-Lite are this design's own decisions.
// Operation
// - While enabled, an unserviced counter resets the whole system.
// - The init-done lock bit sits in the control word and drives initDoneLock.
// - The lock bit only changes through a checked access; bad attempts are errors.
// - An error first raises nmiReq, and reset follows one prewarning period later.
// - The counter ticks at the clock divided by 256 or 16384.
// - Reload is the user value when normal, a fixed value in time-out and prewarning.
// - Access needs a fixed password field plus a user-defined password field.
// - A valid access is two writes, the second inside a limited window.
// - A wrong password on the first or wrong guard on the second write starts reset.
// - Counter overflow starts reset generation.
// - The time-out can be disabled; access checks and lock monitoring stay on.
// - Two watchdog resets without a proper access between hold reset until power-on.
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"

module system_watchdog (
    input  wire        clock,
    input  wire        nrst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        initDoneLock,
    output wire        nmiReq,
    output wire        sysResetReq,
    output wire        irq
);

// ----------------------------------------------------------------
// States and helpers
// ----------------------------------------------------------------
localparam [2:0] ST_TIMEOUT = 3'd0;
localparam [2:0] ST_NORMAL  = 3'd1;
localparam [2:0] ST_PREWARN = 3'd2;
localparam [2:0] ST_RESET   = 3'd3;
localparam [2:0] ST_HOLD    = 3'd4;
// Counts are worked out as integers, then cut to their counter widths
localparam integer WIN_INT  = `ACC_WINDOW_CYC;
localparam integer RST_INT  = `RST_PULSE_CYC;
localparam [15:0] WIN_CYC   = WIN_INT[15:0];
localparam [7:0]  RST_CYC   = RST_INT[7:0];

// One-hot register select, shared by the write and read paths
function [3:0] regSel;
    input [3:0] addr;
    begin
        case (addr)
            `OFS_CTRL:     regSel = 4'h1;
            `OFS_STATE:    regSel = 4'h2;
            `OFS_IRQ_STAT: regSel = 4'h4;
            `OFS_IRQ_MASK: regSel = 4'h8;
            default:       regSel = 4'h0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// AXI4-Lite write channel
// ----------------------------------------------------------------
reg         awHave_ff;
reg         wHave_ff;
reg  [3:0]  awAddr_ff;
reg  [31:0] wData_ff;
reg  [3:0]  wStrb_ff;
wire        wrFire = awHave_ff & wHave_ff & ~s_axi_bvalid;
wire [3:0]  wrSel  = regSel(awAddr_ff);

assign s_axi_awready = ~awHave_ff & ~s_axi_bvalid;
assign s_axi_wready  = ~wHave_ff & ~s_axi_bvalid;

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
        awAddr_ff    <= 4'h0;
        wData_ff     <= 32'h00000000;
        wStrb_ff     <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= {s_axi_awaddr[3:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHave_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end
        if (wrFire) begin
            awHave_ff    <= 1'b0;
            wHave_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrSel == 4'h0) ? 2'h2 : 2'h0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Watchdog core state
// ----------------------------------------------------------------
reg  [2:0]  state_ff;
reg  [15:0] count_ff;
reg  [15:0] reload_ff;
reg  [7:0]  pwd_ff;
reg         lock_ff;
reg         divSel_ff;
reg         disable_ff;
reg         unlocked_ff;
reg  [15:0] winCnt_ff;
reg  [7:0]  rstCnt_ff;
reg         resetSeen_ff;
reg  [2:0]  irqStat_ff;
reg  [2:0]  irqMask_ff;
wire        tick;

wire ctrlWr   = wrFire & wrSel[0];
wire liveMode = (state_ff == ST_TIMEOUT) | (state_ff == ST_NORMAL);
wire pwdOk    = (wData_ff[`F_PWD_HI:`F_PWD_LO] == pwd_ff) &&
                (wData_ff[`F_GUARD_HI:`F_GUARD_LO] == `FIXED_PWD);
wire guardOk  = (wData_ff[`F_GUARD_HI:`F_GUARD_LO] == `GUARD_VAL);
wire firstWr  = ctrlWr & liveMode & ~unlocked_ff;
wire secondWr = ctrlWr & liveMode & unlocked_ff;
wire properWr = secondWr & guardOk;
wire winLapse = liveMode & unlocked_ff & ~ctrlWr & (winCnt_ff == 16'h0000);
wire accErr   = (firstWr & ~pwdOk) | (secondWr & ~guardOk) | winLapse;
wire ovfl     = tick & (count_ff == 16'hffff);
// Time-out mode always guards boot; disable only masks normal overflow
wire ovflErr  = ovfl & ((state_ff == ST_TIMEOUT) |
                        ((state_ff == ST_NORMAL) & ~disable_ff));
wire errEvt   = liveMode & (accErr | ovflErr);

watchdog_prescaler prescaler (
    .clock   (clock),
    .nrst    (nrst),
    .divSel  (divSel_ff),
    .restart (properWr),
    .tick    (tick)
);

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        state_ff     <= ST_TIMEOUT;
        count_ff     <= `TIMEOUT_RELOAD;
        reload_ff    <= `RST_RELOAD;
        pwd_ff       <= `RST_PWD;
        lock_ff      <= 1'b0;
        divSel_ff    <= 1'b0;
        disable_ff   <= 1'b0;
        unlocked_ff  <= 1'b0;
        winCnt_ff    <= 16'h0000;
        rstCnt_ff    <= 8'h00;
        resetSeen_ff <= 1'b0;
    end else begin
        if (unlocked_ff && winCnt_ff != 16'h0000) begin
            winCnt_ff <= winCnt_ff - 16'h0001;
        end
        case (state_ff)
            ST_TIMEOUT, ST_NORMAL: begin
                if (errEvt) begin
                    state_ff    <= ST_PREWARN;
                    count_ff    <= `PREWARN_RELOAD;
                    unlocked_ff <= 1'b0;
                end else if (properWr) begin
                    // Only the checked second write may move the lock bit
                    state_ff     <= ST_NORMAL;
                    lock_ff      <= wData_ff[`F_LOCK];
                    divSel_ff    <= wData_ff[`F_DIVSEL];
                    disable_ff   <= wData_ff[`F_DISABLE];
                    pwd_ff       <= wData_ff[`F_PWD_HI:`F_PWD_LO];
                    reload_ff    <= wData_ff[`F_RELOAD_HI:`F_RELOAD_LO];
                    count_ff     <= wData_ff[`F_RELOAD_HI:`F_RELOAD_LO];
                    unlocked_ff  <= 1'b0;
                    resetSeen_ff <= 1'b0;
                end else begin
                    if (firstWr) begin
                        unlocked_ff <= 1'b1;
                        winCnt_ff   <= WIN_CYC;
                    end
                    if (tick) begin
                        count_ff <= count_ff + 16'h0001;
                    end
                end
            end
            ST_PREWARN: begin
                if (tick) begin
                    count_ff <= count_ff + 16'h0001;
                end
                if (ovfl) begin
                    state_ff  <= resetSeen_ff ? ST_HOLD : ST_RESET;
                    rstCnt_ff <= RST_CYC;
                end
            end
            ST_RESET: begin
                // System reset restores boot defaults of state, counter and control fields, and sets resetSeen_ff
                if (rstCnt_ff == 8'h01) begin
                    state_ff     <= ST_TIMEOUT;
                    count_ff     <= `TIMEOUT_RELOAD;
                    reload_ff    <= `RST_RELOAD;
                    pwd_ff       <= `RST_PWD;
                    lock_ff      <= 1'b0;
                    divSel_ff    <= 1'b0;
                    disable_ff   <= 1'b0;
                    resetSeen_ff <= 1'b1;
                end
                rstCnt_ff <= rstCnt_ff - 8'h01;
            end
            ST_HOLD: begin
                state_ff <= ST_HOLD;
            end
            default: begin
                state_ff <= ST_TIMEOUT;
            end
        endcase
    end
end

assign initDoneLock = lock_ff;
assign nmiReq       = (state_ff == ST_PREWARN);
assign sysResetReq  = (state_ff == ST_RESET) | (state_ff == ST_HOLD);

// ----------------------------------------------------------------
// Interrupt status and mask
// ----------------------------------------------------------------
wire [2:0] irqSet = {errEvt, ovflErr & liveMode, accErr & liveMode};
wire [2:0] irqClr = (wrFire & wrSel[2] & wStrb_ff[0]) ? wData_ff[2:0] : 3'h0;

// A new event in the clearing cycle wins over the clear
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        irqStat_ff <= 3'h0;
        irqMask_ff <= 3'h0;
    end else begin
        irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
        if (wrFire && wrSel[3] && wStrb_ff[0]) begin
            irqMask_ff <= wData_ff[2:0];
        end
    end
end

assign irq = |(irqStat_ff & irqMask_ff);

// ----------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------
wire [3:0] rdSel = regSel({s_axi_araddr[3:2], 2'b00});
reg  [31:0] rdMux;

assign s_axi_arready = ~s_axi_rvalid;

// Password is write-only so a stray read cannot leak it
always @* begin
    rdMux = 32'h00000000;
    case (rdSel)
        4'h1: rdMux = {reload_ff, 8'h00, 4'h0, 1'b0,
                       disable_ff, divSel_ff, lock_ff};
        4'h2: rdMux = {count_ff, 11'h000, unlocked_ff, resetSeen_ff, state_ff};
        4'h4: rdMux = {29'h00000000, irqStat_ff};
        4'h8: rdMux = {29'h00000000, irqMask_ff};
        default: rdMux = 32'h00000000;
    endcase
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= (rdSel == 4'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // system_watchdog
`default_nettype wire

// *** hdl/watchdog_consts.vh ***
/*
 Constants of the system watchdog: register offsets, field positions,
 fixed password and guard values, reload values, interrupt bits, prescaler masks, timing.
 Assumes inclusion by bare name from the watchdog design files.
*/
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        4'h0
`define OFS_STATE       4'h4
`define OFS_IRQ_STAT    4'h8
`define OFS_IRQ_MASK    4'hc

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define F_LOCK          0
`define F_DIVSEL        1
`define F_DISABLE       2
`define F_GUARD_LO      4
`define F_GUARD_HI      7
`define F_PWD_LO        8
`define F_PWD_HI        15
`define F_RELOAD_LO     16
`define F_RELOAD_HI     31
`define FIXED_PWD       4'ha
`define GUARD_VAL       4'h5

// ----------------------------------------------------------------
// Reset and fixed reload values
// ----------------------------------------------------------------
`define RST_RELOAD      16'hfffc
`define RST_PWD         8'h00
`define TIMEOUT_RELOAD  16'hfffc
`define PREWARN_RELOAD  16'hfff0

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define IRQ_ACCERR      0
`define IRQ_OVFL        1
`define IRQ_PREWARN     2
`define IRQ_W           3

// ----------------------------------------------------------------
// Prescaler ratios as terminal counts
// ----------------------------------------------------------------
`define DIV_LOW_MASK    14'h00ff
`define DIV_HIGH_MASK   14'h3fff

// ----------------------------------------------------------------
// Timing: figures in ns, counts derived at the clock period
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define ACC_WINDOW_NS   10000
`define ACC_WINDOW_CYC  (`ACC_WINDOW_NS / `CLK_PERIOD_NS)
`define RST_PULSE_NS    1000
`define RST_PULSE_CYC   ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hdl/watchdog_prescaler.v ***
/*
 Prescaler of the system watchdog: one-cycle tick every 256 or 16384
 clocks. Assumes a synchronous restart request from the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"

module watchdog_prescaler (
    input  wire        clock,
    input  wire        nrst,
    input  wire        divSel,
    input  wire        restart,
    output reg         tick
);

reg  [13:0] div_ff;
wire [13:0] termMask = divSel ? `DIV_HIGH_MASK : `DIV_LOW_MASK;

// Restart keeps the first period after a service a full period long
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        div_ff <= 14'h0000;
        tick   <= 1'b0;
    end else if (restart) begin
        div_ff <= 14'h0000;
        tick   <= 1'b0;
    end else begin
        div_ff <= div_ff + 14'h0001;
        tick   <= ((div_ff & termMask) == termMask);
    end
end

endmodule // watchdog_prescaler
`default_nettype wire

// *** testbench/system_watchdog_props.sv ***
/*
 Checker of the system watchdog ports: prewarning order, reset pulse,
 reset hold, lock line and write answers.
 Assumes it is bound to system_watchdog with its ports matched by name.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"
module system_watchdog_props (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       s_axi_awvalid,
    input  wire logic       s_axi_awready,
    input  wire logic       s_axi_wvalid,
    input  wire logic       s_axi_wready,
    input  wire logic       s_axi_bvalid,
    input  wire logic [1:0] s_axi_bresp,
    input  wire logic       s_axi_rvalid,
    input  wire logic [1:0] s_axi_rresp,
    input  wire logic       initDoneLock,
    input  wire logic       nmiReq,
    input  wire logic       sysResetReq
);
    logic [7:0] highCnt_ff;
    logic [7:0] nxt_highCnt;

    // Saturates so that a permanent hold cannot wrap back to a pulse length
    always @* begin
        if (!sysResetReq) nxt_highCnt = 8'h00;
        else if (highCnt_ff == 8'hff) nxt_highCnt = highCnt_ff;
        else nxt_highCnt = highCnt_ff + 8'h01;
    end
    always @(posedge clock or negedge nrst) begin
        if (!nrst) highCnt_ff <= 8'h00;
        else highCnt_ff <= nxt_highCnt;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_nmiFirst; $rose(sysResetReq) |-> $past(nmiReq); endproperty
    a_nmiFirst: assert property (p_nmiFirst) else $error("reset without prewarning");
    property p_warnSpan; $rose(nmiReq) |-> (nmiReq && !sysResetReq) [*8]; endproperty
    a_warnSpan: assert property (p_warnSpan) else $error("prewarning cut short");
    property p_pulseLen; $fell(sysResetReq) |-> highCnt_ff == `RST_PULSE_CYC; endproperty
    a_pulseLen: assert property (p_pulseLen) else $error("reset pulse length wrong");
    property p_holdStays; sysResetReq && highCnt_ff > `RST_PULSE_CYC |=> sysResetReq; endproperty
    a_holdStays: assert property (p_holdStays) else $error("held reset released");
    property p_afterBoot; $fell(sysResetReq) |-> ##[0:1] !initDoneLock; endproperty
    a_afterBoot: assert property (p_afterBoot) else $error("lock kept over reset");
    property p_lockByWrite; $rose(initDoneLock) |-> $rose(s_axi_bvalid); endproperty
    a_lockByWrite: assert property (p_lockByWrite) else $error("lock set, no write");
    property p_writeAnswer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_writeAnswer: assert property (p_writeAnswer) else $error("write not answered");
    property p_writeOkay; s_axi_bvalid |-> s_axi_bresp == 2'b00 && !s_axi_awready; endproperty
    a_writeOkay: assert property (p_writeOkay) else $error("bad write response");
    // Every word address is mapped, so a read is always answered OKAY
    property p_readOkay; s_axi_rvalid |-> s_axi_rresp == 2'b00; endproperty
    a_readOkay: assert property (p_readOkay) else $error("bad read response");
endmodule // system_watchdog_props
`default_nettype wire

// *** testbench/cpu_bus_model.sv ***
/*
 CPU side model: AXI4-Lite master that services the watchdog.
 Assumes slave ready and valid outputs move only at rising clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        clock,
    output var  logic [3:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    output var  logic [3:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    output var  logic        busTimeout
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, busTimeout} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    end

    // Ready is sampled mid-cycle, so a transfer is known before its edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge clock);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clock);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) return;
        end
        busTimeout <= 1'b1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic ar, r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge clock);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge clock);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) return;
        end
        busTimeout <= 1'b1;
    endtask
endmodule // cpu_bus_model
`default_nettype wire

// *** testbench/testbench.sv ***
/*
 Testbench of the system watchdog: service sequences, errors, resets.
 Assumes cpu_bus_model and the checker are compiled beforehand.
*/
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"
module testbench;
    logic        clock, nrst, busTimeout, irq, initDoneLock, nmiReq, sysResetReq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr, s_axi_araddr;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          mismatches, n_checks;
    // Responses are always accepted at once; the slave never sees a stall
    wire logic       s_axi_bready = 1'b1;
    wire logic       s_axi_rready = 1'b1;
    wire logic [3:0] s_axi_wstrb = 4'hf;

    system_watchdog dut_u (.*);
    cpu_bus_model   busU (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdCmp(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        busU.rd(a, d);
        cmp(d, exp);
    endtask
    // Order: lock line, prewarning, reset request, interrupt
    task automatic chkOuts(input logic [3:0] exp);
        @(negedge clock);
        cmp({28'h0, initDoneLock, nmiReq, sysResetReq, irq}, {28'h0, exp});
        @(posedge clock);
    endtask
    task automatic waitOut(input logic sel, input logic lvl, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(negedge clock);
            if ((sel ? sysResetReq : nmiReq) === lvl) begin
                n_checks++;
                @(posedge clock);
                return;
            end
        end
        mismatches++;
        end_of_test();
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge busTimeout) begin
        mismatches++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chkOuts(4'b0000);
        rdCmp(`OFS_CTRL, 32'hfffc0000);
        rdCmp(`OFS_STATE, 32'hfffc0000);
        busU.wr(`OFS_CTRL, 32'h000000a0);
        busU.wr(`OFS_CTRL, 32'hfffe1255);
        chkOuts(4'b1000);
        rdCmp(`OFS_CTRL, 32'hfffe0005);
        rdCmp(`OFS_STATE, 32'hfffe0001);
        repeat (1000) @(posedge clock);
        chkOuts(4'b1000);
        // Slow prescaler: a reload of 0xffff must not tick within 300 clocks
        busU.wr(`OFS_CTRL, 32'h000012a0);
        busU.wr(`OFS_CTRL, 32'hffff1253);
        repeat (300) @(posedge clock);
        rdCmp(`OFS_STATE, 32'hffff0001);
        busU.wr(`OFS_CTRL, 32'h000012a0);
        busU.wr(`OFS_CTRL, 32'hfffe1255);
        // Stale password while disabled; the error interrupt starts masked
        busU.wr(`OFS_CTRL, 32'h000000a0);
        waitOut(1'b0, 1'b1, 20);
        chkOuts(4'b1100);
        rdCmp(`OFS_IRQ_STAT, 32'h00000005);
        busU.wr(`OFS_IRQ_MASK, 32'h00000001);
        chkOuts(4'b1101);
        busU.wr(`OFS_IRQ_STAT, 32'h00000001);
        chkOuts(4'b1100);
        waitOut(1'b1, 1'b1, 4300);
        waitOut(1'b1, 1'b0, 120);
        chkOuts(4'b0000);
        rdCmp(`OFS_STATE, 32'hfffc0008);
        busU.wr(`OFS_CTRL, 32'h000000a0);
        busU.wr(`OFS_CTRL, 32'hff001250);
        rdCmp(`OFS_STATE, 32'hff000001);
        // First write only: the missing second write must become an error
        busU.wr(`OFS_CTRL, 32'h000012a0);
        rdCmp(`OFS_STATE, 32'hff000011);
        repeat (950) @(posedge clock);
        chkOuts(4'b0000);
        waitOut(1'b0, 1'b1, 100);
        waitOut(1'b1, 1'b1, 4300);
        waitOut(1'b1, 1'b0, 120);
        busU.wr(`OFS_IRQ_MASK, 32'h00000000);
        // Prescaler keeps its phase over the pulse: overflow lands 924 clocks after it
        repeat (850) @(posedge clock);
        chkOuts(4'b0000);
        waitOut(1'b0, 1'b1, 100);
        rdCmp(`OFS_IRQ_STAT, 32'h00000007);
        waitOut(1'b1, 1'b1, 4300);
        repeat (300) @(posedge clock);
        chkOuts(4'b0010);
        nrst <= 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chkOuts(4'b0000);
        end_of_test();
    end
endmodule // testbench
bind system_watchdog system_watchdog_props propsU (.*);
`default_nettype wire
